// [logic/flash_host_cfg.svh]
// Constants for the sector flash host controller: register map, fields, timing.
// Assumes a 100 MHz system clock; times are kept in their own units.
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FH_OFF_CTRL 4'h0
`define FH_OFF_ADDR 4'h1
`define FH_OFF_BUF 4'h2
`define FH_OFF_PTR 4'h3
`define FH_OFF_STATUS 4'h4
`define FH_OFF_RDATA 4'h5
`define FH_OFF_WDATA 4'h6

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define FH_CTRL_CMD_LSB 0
`define FH_CTRL_PREFIX_BIT 3
`define FH_ST_BUSY 0
`define FH_ST_DONE 1
`define FH_ST_TIMEOUT 2
`define FH_ST_LATE 3
`define FH_ST_LOCKED 4
`define FH_ST_READY 5
`define FH_ST_REFUSED 6
`define FH_ST_POLL7 7
`define FH_ADDR_RESET 17'h00000
`define FH_BYTE_RESET 8'h00

// ----------------------------------------------------------------------------
// Geometry and fixed codes
// ----------------------------------------------------------------------------
`define FH_SECTOR_BYTES 8'h80
`define FH_PREFIX_LEN 8'h03
`define FH_BOOT_UNLOCKED 8'hFE
`define FH_BOOT_LOCKED 8'hFF
`define FH_GUARD_ADDR0 17'h05555
`define FH_GUARD_ADDR1 17'h02AAA
`define FH_GUARD_ADDR2 17'h05555
`define FH_GUARD_DATA0 8'hAA
`define FH_GUARD_DATA1 8'h55
`define FH_GUARD_DATA2 8'hA0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FH_CLK_NS 10
`define FH_SYNC_CYC 2
`define FH_FILTER_NS 15
`define FH_WE_LOW_CYC ((`FH_FILTER_NS + `FH_CLK_NS) / `FH_CLK_NS)
`define FH_ACCESS_NS 90
`define FH_READ_CYC ((`FH_ACCESS_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_POWER_ON_MS 5
`define FH_POWER_ON_CYC ((`FH_POWER_ON_MS * 1000000) / `FH_CLK_NS)
`define FH_LOAD_WINDOW_US 150
`define FH_LOAD_WINDOW_CYC ((`FH_LOAD_WINDOW_US * 1000) / `FH_CLK_NS)
`define FH_PROG_MAX_MS 10
`define FH_PROG_MAX_CYC ((`FH_PROG_MAX_MS * 1000000) / `FH_CLK_NS)

`endif

// [logic/flash_host_pkg.sv]
// Types for the sector flash host controller.
// Assumes nothing beyond a SystemVerilog compiler.
package flash_host_pkg;

    // ------------------------------------------------------------------------
    // Commands and states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_READ = 3'h1,
        CMD_PROG = 3'h2,
        CMD_BYTE = 3'h3,
        CMD_POLL = 3'h4
    } cmd_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_W_PREP = 4'h1,
        ST_W_ADDR = 4'h2,
        ST_W_LOW = 4'h3,
        ST_W_HIGH = 4'h4,
        ST_W_END = 4'h5,
        ST_RD = 4'h6,
        ST_P_RD = 4'h7,
        ST_P_GAP = 4'h8
    } state_t;

endpackage

// [logic/sector_buffer.sv]
// One sector of staged write data, 128 bytes, written by software.
// Assumes one clock; read data come out of a register one cycle after the address.
`timescale 1ns/1ns
`default_nettype none

module sector_buffer (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data
);

    logic [7:0] mem [0:127];

    // Contents are not reset; unloaded bytes are whatever software left there
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

`default_nettype wire

// [logic/sector_flash_program_control.sv]
// Host controller that drives a byte-wide sector flash through its pins.
// Assumes a software master on the plain register port and the flash on the pins.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_cfg.svh"

module sector_flash_program_control #(
    parameter int POWER_ON_CYC = `FH_POWER_ON_CYC,
    parameter int LOAD_WINDOW_CYC = `FH_LOAD_WINDOW_CYC,
    parameter int PROG_MAX_CYC = `FH_PROG_MAX_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [16:0] addr_lines,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_in
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [16:0] guard_addr(input logic [1:0] idx);
        unique case (idx)
            2'h0: guard_addr = `FH_GUARD_ADDR0;
            2'h1: guard_addr = `FH_GUARD_ADDR1;
            default: guard_addr = `FH_GUARD_ADDR2;
        endcase
    endfunction

    function automatic logic [7:0] guard_data(input logic [1:0] idx);
        unique case (idx)
            2'h0: guard_data = `FH_GUARD_DATA0;
            2'h1: guard_data = `FH_GUARD_DATA1;
            default: guard_data = `FH_GUARD_DATA2;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    flash_host_pkg::state_t state_reg, state_next;
    flash_host_pkg::cmd_t cmd_reg;
    logic prefix_reg;
    logic [16:0] addr_reg, last_addr_reg, addr_lines_next;
    logic [7:0] wdata_reg, rdata_reg, dq_out_next;
    logic [6:0] ptr_reg;
    logic [7:0] seq_reg, seq_next;
    logic [3:0] tmr_reg, tmr_next;
    logic [19:0] pwr_reg, gap_reg, poll_reg;
    logic ready_reg, done_reg, timeout_reg, late_reg, locked_reg, refused_reg;
    logic gap_run_reg, first_reg, bit6_reg, poll7_reg;
    logic [7:0] dq_meta_reg, dq_sync_reg;
    logic [7:0] buf_rdata;
    logic [31:0] status_word;

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    wire idle = state_reg == flash_host_pkg::ST_IDLE;
    wire ctrl_wr = reg_wr && reg_addr == `FH_OFF_CTRL;
    wire [2:0] ctrl_cmd = reg_wdata[`FH_CTRL_CMD_LSB +: 3];
    wire prog_like = ctrl_cmd == flash_host_pkg::CMD_PROG || ctrl_cmd == flash_host_pkg::CMD_BYTE;
    wire refuse = ctrl_wr && idle && prog_like && !ready_reg;
    wire go = ctrl_wr && idle && !refuse && ctrl_cmd != flash_host_pkg::CMD_NONE;
    wire buf_wr = reg_wr && reg_addr == `FH_OFF_BUF;
    wire is_prog = cmd_reg == flash_host_pkg::CMD_PROG;
    wire [7:0] pre_len = prefix_reg ? `FH_PREFIX_LEN : 8'h00;
    wire in_prefix = prefix_reg && seq_reg < `FH_PREFIX_LEN;
    wire [7:0] body_idx = seq_reg - pre_len;
    wire [7:0] seq_last = pre_len + (is_prog ? `FH_SECTOR_BYTES - 8'h01 : 8'h00);
    wire read_end = tmr_reg == 4'h0;
    wire poll_stop = !first_reg && dq_sync_reg[6] == bit6_reg;
    wire poll_out = poll_reg >= PROG_MAX_CYC[19:0];
    wire late_now = go && ctrl_cmd == flash_host_pkg::CMD_BYTE && gap_run_reg
        && gap_reg >= LOAD_WINDOW_CYC[19:0];
    wire finishing = (state_reg == flash_host_pkg::ST_W_END && seq_reg == seq_last && !is_prog)
        || (state_reg == flash_host_pkg::ST_RD && read_end)
        || (state_reg == flash_host_pkg::ST_P_GAP && (poll_stop || poll_out));

    assign status_word = {24'h000000, poll7_reg, refused_reg, ready_reg, locked_reg,
        late_reg, timeout_reg, done_reg, !idle};

    // Strobes follow the next state so every pin leaves a flip-flop
    wire w_drive = state_next == flash_host_pkg::ST_W_ADDR || state_next == flash_host_pkg::ST_W_LOW
        || state_next == flash_host_pkg::ST_W_HIGH;
    wire r_drive = state_next == flash_host_pkg::ST_RD || state_next == flash_host_pkg::ST_P_RD;

    sector_buffer u_buf (
        .sys_clk(sys_clk),
        .wr_en(buf_wr),
        .wr_addr(ptr_reg),
        .wr_data(reg_wdata[7:0]),
        .rd_addr(body_idx[6:0]),
        .rd_data(buf_rdata)
    );

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        seq_next = seq_reg;
        tmr_next = tmr_reg;
        addr_lines_next = addr_lines;
        dq_out_next = flash_dq_out;
        unique case (state_reg)
            flash_host_pkg::ST_IDLE: begin
                seq_next = 8'h00;
                if (go) begin
                    unique case (ctrl_cmd)
                        flash_host_pkg::CMD_READ: begin
                            state_next = flash_host_pkg::ST_RD;
                            addr_lines_next = addr_reg;
                            tmr_next = 4'(`FH_READ_CYC + `FH_SYNC_CYC);
                        end
                        flash_host_pkg::CMD_POLL: begin
                            state_next = flash_host_pkg::ST_P_RD;
                            addr_lines_next = last_addr_reg;
                            tmr_next = 4'(`FH_READ_CYC + `FH_SYNC_CYC);
                        end
                        default: state_next = flash_host_pkg::ST_W_PREP;
                    endcase
                end
            end
            flash_host_pkg::ST_W_PREP: begin
                state_next = flash_host_pkg::ST_W_ADDR;
                // Address leads the falling write strobe by a cycle, never racing it
                addr_lines_next = in_prefix ? guard_addr(seq_reg[1:0])
                    : is_prog ? {addr_reg[16:7], body_idx[6:0]}
                    : addr_reg;
            end
            flash_host_pkg::ST_W_ADDR: begin
                state_next = flash_host_pkg::ST_W_LOW;
                tmr_next = 4'(`FH_WE_LOW_CYC - 1);
                if (in_prefix) begin
                    dq_out_next = guard_data(seq_reg[1:0]);
                end else if (is_prog) begin
                    dq_out_next = buf_rdata;
                end else begin
                    dq_out_next = wdata_reg;
                end
            end
            flash_host_pkg::ST_W_LOW: begin
                tmr_next = tmr_reg - 4'h1;
                if (tmr_reg == 4'h0) begin
                    state_next = flash_host_pkg::ST_W_HIGH;
                end
            end
            flash_host_pkg::ST_W_HIGH: begin
                state_next = flash_host_pkg::ST_W_END;
            end
            flash_host_pkg::ST_W_END: begin
                seq_next = seq_reg + 8'h01;
                if (seq_reg != seq_last) begin
                    state_next = flash_host_pkg::ST_W_PREP;
                end else if (is_prog) begin
                    state_next = flash_host_pkg::ST_P_RD;
                    tmr_next = 4'(`FH_READ_CYC + `FH_SYNC_CYC);
                end else begin
                    state_next = flash_host_pkg::ST_IDLE;
                end
            end
            flash_host_pkg::ST_RD: begin
                tmr_next = tmr_reg - 4'h1;
                if (read_end) begin
                    state_next = flash_host_pkg::ST_IDLE;
                end
            end
            flash_host_pkg::ST_P_RD: begin
                tmr_next = tmr_reg - 4'h1;
                if (read_end) begin
                    state_next = flash_host_pkg::ST_P_GAP;
                end
            end
            flash_host_pkg::ST_P_GAP: begin
                tmr_next = 4'(`FH_READ_CYC + `FH_SYNC_CYC);
                state_next = (poll_stop || poll_out) ? flash_host_pkg::ST_IDLE
                    : flash_host_pkg::ST_P_RD;
            end
            default: state_next = flash_host_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= flash_host_pkg::ST_IDLE;
            seq_reg <= 8'h00;
            tmr_reg <= 4'h0;
            addr_lines <= `FH_ADDR_RESET;
            flash_dq_out <= `FH_BYTE_RESET;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            dq_meta_reg <= 8'h00;
            dq_sync_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            seq_reg <= seq_next;
            tmr_reg <= tmr_next;
            addr_lines <= addr_lines_next;
            flash_dq_out <= dq_out_next;
            flash_ce_n <= !(w_drive || r_drive);
            flash_oe_n <= !r_drive;
            flash_we_n <= state_next != flash_host_pkg::ST_W_LOW;
            flash_dq_oe <= w_drive;
            dq_meta_reg <= flash_dq_in;
            dq_sync_reg <= dq_meta_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Software registers and status
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_reg <= flash_host_pkg::CMD_NONE;
            prefix_reg <= 1'b0;
            addr_reg <= `FH_ADDR_RESET;
            last_addr_reg <= `FH_ADDR_RESET;
            wdata_reg <= `FH_BYTE_RESET;
            rdata_reg <= `FH_BYTE_RESET;
            ptr_reg <= 7'h00;
            reg_rdata <= 32'h00000000;
            {done_reg, timeout_reg, late_reg, locked_reg, refused_reg} <= 5'h00;
            {ready_reg, gap_run_reg, first_reg, bit6_reg, poll7_reg} <= 5'h00;
            pwr_reg <= 20'h00000;
            gap_reg <= 20'h00000;
            poll_reg <= 20'h00000;
        end else begin
            // Power-up hold-off before any program traffic
            if (!ready_reg) begin
                pwr_reg <= pwr_reg + 20'h00001;
                ready_reg <= pwr_reg >= 20'(POWER_ON_CYC - 1);
            end
            if (go) begin
                cmd_reg <= flash_host_pkg::cmd_t'(ctrl_cmd);
                prefix_reg <= reg_wdata[`FH_CTRL_PREFIX_BIT];
                first_reg <= 1'b1;
                poll_reg <= 20'h00000;
            end
            if (reg_wr && reg_addr == `FH_OFF_ADDR) begin
                addr_reg <= reg_wdata[16:0];
            end
            if (reg_wr && reg_addr == `FH_OFF_WDATA) begin
                wdata_reg <= reg_wdata[7:0];
            end
            if (reg_wr && reg_addr == `FH_OFF_PTR) begin
                ptr_reg <= reg_wdata[6:0];
            end else if (buf_wr) begin
                ptr_reg <= ptr_reg + 7'h01;
            end
            // Gap counter since the last rising strobe; saturates
            if (state_reg == flash_host_pkg::ST_W_HIGH) begin
                gap_reg <= 20'h00000;
                gap_run_reg <= 1'b1;
                last_addr_reg <= addr_lines;
            end else if (gap_reg != 20'hFFFFF) begin
                gap_reg <= gap_reg + 20'h00001;
            end
            if (state_reg == flash_host_pkg::ST_P_RD || state_reg == flash_host_pkg::ST_P_GAP) begin
                poll_reg <= poll_reg + 20'h00001;
            end
            if (state_reg == flash_host_pkg::ST_P_GAP) begin
                first_reg <= 1'b0;
                bit6_reg <= dq_sync_reg[6];
                poll7_reg <= dq_sync_reg[7];
            end
            if (state_reg == flash_host_pkg::ST_RD && read_end) begin
                rdata_reg <= dq_sync_reg;
                locked_reg <= dq_sync_reg == `FH_BOOT_LOCKED;
            end
            // Sticky flags: a new command clears, completion sets done and timeout; the command write itself sets late and refused
            done_reg <= finishing || (done_reg && !go);
            timeout_reg <= (state_reg == flash_host_pkg::ST_P_GAP && !poll_stop && poll_out)
                || (timeout_reg && !go);
            late_reg <= late_now || (late_reg && !(go && !late_now));
            refused_reg <= refuse || (refused_reg && !go);
            unique case (reg_addr)
                `FH_OFF_ADDR: reg_rdata <= reg_rd ? {15'h0000, addr_reg} : 32'h00000000;
                `FH_OFF_PTR: reg_rdata <= reg_rd ? {25'h0000000, ptr_reg} : 32'h00000000;
                `FH_OFF_STATUS: reg_rdata <= reg_rd ? status_word : 32'h00000000;
                `FH_OFF_RDATA: reg_rdata <= reg_rd ? {24'h000000, rdata_reg} : 32'h00000000;
                `FH_OFF_WDATA: reg_rdata <= reg_rd ? {24'h000000, wdata_reg} : 32'h00000000;
                default: reg_rdata <= 32'h00000000;
            endcase
        end
    end

endmodule

`default_nettype wire

// [tb/flash_host_properties.sv]
// Checker for the host controller pins and its software port.
// Assumes it is bound to the controller top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module flash_host_properties #(
    parameter int POWER_ON_CYC = 20,
    parameter int LOAD_WINDOW_CYC = 50,
    parameter int PROG_MAX_CYC = 2000
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [16:0] addr_lines,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic [7:0] flash_dq_out,
    input wire logic flash_dq_oe,
    input wire logic [7:0] flash_dq_in
);
    // ----------------------------------------------------------------
    // Byte-load history
    // ----------------------------------------------------------------
    logic [31:0] gap_cnt;
    logic [9:0] last_sec;
    logic [7:0] last_off;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_cnt <= 32'h0;
            last_sec <= 10'h000;
            last_off <= 8'hFE;
        end else if (!flash_we_n) begin
            gap_cnt <= 32'h0;
            last_sec <= addr_lines[16:7];
            last_off <= {1'b0, addr_lines[6:0]};
        end else begin
            gap_cnt <= gap_cnt + 32'h1;
        end
    end
    // Guard bytes never follow each other by offset, so only sector bytes match
    wire seq_byte = {1'b0, addr_lines[6:0]} == last_off + 8'h01;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------------------------------
    // Pin rules
    // ----------------------------------------------------------------
    AST_READ_HELD: assert property ($fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n)[*8])
        else $error("read strobes released early");
    AST_NO_DRIVE_OFF: assert property (flash_ce_n || !flash_oe_n |-> !flash_dq_oe)
        else $error("data driven outside a write");
    AST_LOAD_FRAME: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
        else $error("write strobe outside select");
    AST_LOAD_STABLE: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(addr_lines) && $stable(flash_dq_out))
        else $error("address or data moved in load");
    AST_NO_OE_WRITE: assert property ($fell(flash_we_n) |->
        $past(flash_oe_n) ##0 flash_oe_n[*3])
        else $error("output enable low near load");
    AST_WE_WIDTH: assert property ($fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
        else $error("write pulse width wrong");
    AST_SECTOR_HOLD: assert property ($fell(flash_we_n) && seq_byte |-> addr_lines[16:7] == last_sec)
        else $error("sector bits changed in load");
    AST_LOAD_GAP: assert property ($fell(flash_we_n) && seq_byte |-> gap_cnt < LOAD_WINDOW_CYC)
        else $error("byte load gap too long");
    COV_LOAD: cover property ($fell(flash_we_n) && seq_byte);
    COV_READ: cover property ($fell(flash_oe_n));
    COV_CMD: cover property (reg_wr && reg_addr == 4'h0);
endmodule
`default_nettype wire

// [tb/flash_device_model.sv]
// Behavioural byte-wide sector flash on the controller pins.
// Assumes the host resolves nothing: this model also forms the data wire level.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_cfg.svh"
module flash_device_model #(
    parameter int WIN_NS = 400,
    parameter int PROG_NS = 3000,
    parameter int PWR_NS = 100
) (
    input wire logic [16:0] addr_lines,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] host_dq,
    input wire logic host_oe,
    output logic [7:0] dq
);
    logic [7:0] mem [0:131071];
    logic [7:0] pg [0:127];
    logic [127:0] ld = '0;
    logic [16:0] a = 17'h0;
    logic [9:0] sec = 10'h0;
    logic [7:0] d = 8'h0;
    logic [7:0] last_q = 8'h0;
    logic guard_on = 1'b0; // No reset reaches it, so it outlives power cycles
    logic loading = 1'b0;
    logic busy = 1'b0;
    logic allow = 1'b0;
    logic tg = 1'b0;
    int k = 0;
    time t_fall = 0;
    time t_rise = 0;
    time t_end = 0;
    wire rd_on = !ce_n && !oe_n && we_n;
    wire [7:0] rv = (loading || busy) ? {~d[7], tg, d[5:0]} : mem[addr_lines];
    function automatic logic hit(input int n, input logic [16:0] x, input logic [7:0] y);
        case (n)
            0: hit = x == `FH_GUARD_ADDR0 && y == `FH_GUARD_DATA0;
            1: hit = x == `FH_GUARD_ADDR1 && y == `FH_GUARD_DATA1;
            default: hit = x == `FH_GUARD_ADDR2 && y == `FH_GUARD_DATA2;
        endcase
    endfunction
    initial for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
    always @(negedge we_n) begin
        a = addr_lines;
        t_fall = $time;
    end
    // Short pulses, inhibits and the power-on delay all drop the load
    always @(posedge we_n) if (!ce_n && oe_n && $time - t_fall >= 15 && $time > PWR_NS && !busy) begin
        d = host_dq;
        if (k < 3 && hit(k, a, d)) begin
            k = k + 1;
        end else begin
            pg[a[6:0]] = d;
            ld[a[6:0]] = 1'b1;
            sec = a[16:7];
        end
        loading = 1'b1;
        t_rise = $time;
    end
    always @(posedge rd_on) if (loading || busy) tg = ~tg;
    always #10 begin
        if (loading && we_n && $time - t_rise > WIN_NS) begin
            loading = 1'b0;
            busy = 1'b1;
            t_end = $time + PROG_NS;
            allow = !guard_on || k == 3;
            if (k == 3) guard_on = 1'b1;
            k = 0;
        end
        if (busy && $time >= t_end) begin
            if (allow && ld != '0) begin
                for (int i = 0; i < 128; i++) mem[{sec, i[6:0]}] = ld[i] ? pg[i] : ~mem[{sec, i[6:0]}];
            end
            ld = '0;
            busy = 1'b0;
        end
    end
    always @* if (rd_on) last_q = rv;
    // Released lines show the inverse of the last byte, not a held value
    assign dq = host_oe ? host_dq : rd_on ? rv : ~last_q;
endmodule
`default_nettype wire

// [tb/test_sector_flash_program_control.sv]
// Self-checking bench for the sector flash host controller.
// Assumes the flash model on the pins and the checker bound below.
`timescale 1ns/1ns
`default_nettype none
module test_sector_flash_program_control;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [16:0] addr_lines;
    logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
    logic [7:0] flash_dq_out, flash_dq_in;
    logic [31:0] st = 32'h0;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    always #5 sys_clk = ~sys_clk;
    sector_flash_program_control #(.POWER_ON_CYC(20), .LOAD_WINDOW_CYC(50), .PROG_MAX_CYC(2000)) uut (
        .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_lines(addr_lines),
        .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
        .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in));
    flash_device_model flash (.addr_lines(addr_lines), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
        .we_n(flash_we_n), .host_dq(flash_dq_out), .host_oe(flash_dq_oe), .dq(flash_dq_in));
    task automatic results();
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_bit(input int b);
        st = 32'h0;
        for (int n = 0; n < 3000 && st[b] !== 1'b1; n++) rd(4'h4, st);
    endtask
    task automatic prog(input logic [16:0] a, input logic [7:0] s, input logic g);
        wr(4'h1, {15'h0, a});
        wr(4'h3, 32'h0);
        for (int i = 0; i < 128; i++) wr(4'h2, {24'h0, s + i[7:0]});
        wr(4'h0, {28'h0, g, 3'h2});
        wait_bit(1);
        chk("late or timeout flags", 32'h0, st & 32'h0000004C);
    endtask
    task automatic rdb(input logic [16:0] a, input logic [7:0] e);
        wr(4'h1, {15'h0, a});
        wr(4'h0, 32'h1);
        wait_bit(1);
        chk("locked flag", {27'h0, e == 8'hFF, 4'h0}, st & 32'h10);
        rd(4'h5, st);
        chk("flash byte", {24'h0, e}, st);
    endtask
    task automatic rdsec(input logic [16:0] a, input logic [7:0] s);
        for (int j = 0; j < 128; j += 63) rdb(a + j[16:0], s + j[7:0]);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        wr(4'h0, 32'h2);
        rd(4'h4, st);
        chk("early program", 32'h40, st & 32'h60);
        wait_bit(5);
        prog(17'h1AB80, 8'h10, 1'b0);
        rdsec(17'h1AB80, 8'h10);
        prog(17'h1AB80, 8'h40, 1'b1);
        rdsec(17'h1AB80, 8'h40);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        wait_bit(5);
        prog(17'h1AB80, 8'h70, 1'b0);
        rdsec(17'h1AB80, 8'h40);
        prog(17'h1AB80, 8'h70, 1'b1);
        rdsec(17'h1AB80, 8'h70);
        rd(4'h1, st);
        chk("address register", 32'h0001ABFE, st);
        rd(4'hF, st);
        chk("unmapped read", 32'h0, st);
        wr(4'h6, 32'h5A);
        wr(4'h1, 32'h2);
        wr(4'h0, 32'hB);
        wait_bit(1);
        chk("late flag", 32'h8, st & 32'h8);
        wr(4'h0, 32'h4);
        wait_bit(1);
        chk("poll flags", 32'h2, st & 32'hF);
        rdb(17'h00002, 8'h5A);
        rdb(17'h1FFF2, 8'hFF);
        results();
    end
endmodule
bind sector_flash_program_control flash_host_properties #(.POWER_ON_CYC(POWER_ON_CYC),
    .LOAD_WINDOW_CYC(LOAD_WINDOW_CYC), .PROG_MAX_CYC(PROG_MAX_CYC)) chk_pins (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_lines(addr_lines),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in));
`default_nettype wire
